// [rtl/dual_chan_regs.sv]
// Register bank of a dual-channel converter: power-down, range, commands,
// broadcast and per-channel codes. Assumes the serial frame decoder upstream
// delivers one-cycle write strobes with address and data, and a one-cycle
// strobe for the serial select rising edge.
//
// Behaviour
// - Power-down bit per channel grounds output
// - Power-down register resets all ones; reserved bits read one
// - Range codes at bits 11-8 and 7-4
// - Range register resets zero, write-only
// - Trigger bit 9 clears all outputs
// - Trigger bit 8 clears alarm, not busy
// - Trigger bit 4 loads synchronous channels
// - Code 1010 in bits 3-0 resets device
// - Broadcast write loads enabled channels only
// - Codes MSB aligned; 12-bit ignores low four
// - Channel codes at 11h, 12h reset zero
// - Broadcast enable bits reset to one
// - Sync bit selects load trigger or select-edge
`timescale 1ns/1ps
module dual_chan_regs #(
  parameter int code_bits = 16 // 16 or 12 significant code bits
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic write_strobe, // One-cycle register write
  input wire logic [6:0] write_addr,
  input wire logic [15:0] write_data,
  input wire logic select_rise, // Serial select rising edge pulse
  input wire logic load_trigger_pin, // External load pulse, synchronous
  output logic [15:0] channel_power_down, // Readable power-down register
  output logic chan_a_power_down,
  output logic chan_b_power_down,
  output dual_chan_regs_pkg::range_kind_type chan_a_range,
  output dual_chan_regs_pkg::range_kind_type chan_b_range,
  output logic [15:0] chan_a_output_code, // Live output code
  output logic [15:0] chan_b_output_code,
  output logic alarm_clear_pulse, // To alarm logic; busy alarm excluded
  output logic soft_reset_pulse // Device-wide reset request
);

  // ****************************************
  // State
  // ****************************************
  logic [15:0] channel_output_range; // Write-only range register
  logic [15:0] broadcast_enable_cfg; // Broadcast enables
  logic [15:0] update_mode_cfg; // Sync-mode enables
  logic [15:0] channel_code [2]; // Pending data registers
  logic [15:0] output_code [2]; // Active codes
  logic [15:0] next_power_down, next_range, next_bcast_cfg, next_update_cfg;
  logic [15:0] next_code [2];
  logic [15:0] next_output [2];
  logic next_alarm_clear, next_soft_reset;
  dual_chan_regs_pkg::range_kind_type kind_a, kind_b;
  logic [15:0] code_mask; // Drops low bits on the 12-bit variant
  logic [15:0] masked_data;
  logic wr_trigger, do_reset, do_clear, do_load;

  assign code_mask = 16'hffff << (16 - code_bits);
  assign masked_data = write_data & code_mask;
  assign wr_trigger = write_strobe && (write_addr == dual_chan_regs_pkg::addr_command_trigger);
  // Exact code only, so stray writes cannot reset the part
  assign do_reset = wr_trigger && (write_data[3:0] == dual_chan_regs_pkg::soft_reset_code);
  assign do_clear = wr_trigger && write_data[dual_chan_regs_pkg::clear_outputs_bit];
  // Software load joins the pin as the same load event
  assign do_load = load_trigger_pin ||
    (wr_trigger && write_data[dual_chan_regs_pkg::sync_load_bit]);

  // ****************************************
  // Range decoders
  // ****************************************
  range_decoder dec_a (
    .code(channel_output_range[dual_chan_regs_pkg::range_a_lsb +: 4]),
    .kind(kind_a)
  );
  range_decoder dec_b (
    .code(channel_output_range[dual_chan_regs_pkg::range_b_lsb +: 4]),
    .kind(kind_b)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  // Soft reset beats every other write in the same cycle
  always_comb begin
    next_power_down = channel_power_down;
    next_range = channel_output_range;
    next_bcast_cfg = broadcast_enable_cfg;
    next_update_cfg = update_mode_cfg;
    next_code = channel_code;
    next_output = output_code;
    // Commands are pulses, never stored
    next_alarm_clear = wr_trigger && write_data[dual_chan_regs_pkg::alarm_clear_bit];
    next_soft_reset = do_reset;
    if (do_reset) begin
      next_power_down = dual_chan_regs_pkg::power_down_reset;
      next_range = dual_chan_regs_pkg::range_reset;
      next_bcast_cfg = dual_chan_regs_pkg::broadcast_cfg_reset;
      next_update_cfg = dual_chan_regs_pkg::update_cfg_reset;
      next_code = '{dual_chan_regs_pkg::code_reset, dual_chan_regs_pkg::code_reset};
      next_output = '{dual_chan_regs_pkg::code_reset, dual_chan_regs_pkg::code_reset};
      next_alarm_clear = 1'b0;
    end else begin
      if (write_strobe) begin
        // Only channel bits writable; reserved ones keep fixed values
        if (write_addr == dual_chan_regs_pkg::addr_channel_power_down) begin
          next_power_down[dual_chan_regs_pkg::chan_a_bit] = write_data[dual_chan_regs_pkg::chan_a_bit];
          next_power_down[dual_chan_regs_pkg::chan_b_bit] = write_data[dual_chan_regs_pkg::chan_b_bit];
        end else if (write_addr == dual_chan_regs_pkg::addr_channel_output_range) begin
          next_range = {4'h0, write_data[11:4], 4'h0};
        end else if (write_addr == dual_chan_regs_pkg::addr_broadcast_enable_cfg) begin
          next_bcast_cfg[dual_chan_regs_pkg::chan_a_bit] = write_data[dual_chan_regs_pkg::chan_a_bit];
          next_bcast_cfg[dual_chan_regs_pkg::chan_b_bit] = write_data[dual_chan_regs_pkg::chan_b_bit];
        end else if (write_addr == dual_chan_regs_pkg::addr_update_mode_cfg) begin
          next_update_cfg[dual_chan_regs_pkg::chan_a_bit] = write_data[dual_chan_regs_pkg::chan_a_bit];
          next_update_cfg[dual_chan_regs_pkg::chan_b_bit] = write_data[dual_chan_regs_pkg::chan_b_bit];
        end else if (write_addr == dual_chan_regs_pkg::addr_broadcast_code) begin
          // Only channels with broadcast enabled follow
          if (broadcast_enable_cfg[dual_chan_regs_pkg::chan_a_bit]) begin
            next_code[0] = masked_data;
          end
          if (broadcast_enable_cfg[dual_chan_regs_pkg::chan_b_bit]) begin
            next_code[1] = masked_data;
          end
        end else if (write_addr == dual_chan_regs_pkg::addr_channel_code_a) begin
          next_code[0] = masked_data;
        end else if (write_addr == dual_chan_regs_pkg::addr_channel_code_b) begin
          next_code[1] = masked_data;
        end
      end
      // Output update: select edge for async channels, load for sync ones
      if (select_rise && !update_mode_cfg[dual_chan_regs_pkg::chan_a_bit]) begin
        next_output[0] = next_code[0];
      end
      if (select_rise && !update_mode_cfg[dual_chan_regs_pkg::chan_b_bit]) begin
        next_output[1] = next_code[1];
      end
      if (do_load && update_mode_cfg[dual_chan_regs_pkg::chan_a_bit]) begin
        next_output[0] = channel_code[0];
      end
      if (do_load && update_mode_cfg[dual_chan_regs_pkg::chan_b_bit]) begin
        next_output[1] = channel_code[1];
      end
      // Clear wins over any load in the same cycle
      if (do_clear) begin
        next_output = '{dual_chan_regs_pkg::code_reset, dual_chan_regs_pkg::code_reset};
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      channel_power_down <= dual_chan_regs_pkg::power_down_reset;
      channel_output_range <= dual_chan_regs_pkg::range_reset;
      broadcast_enable_cfg <= dual_chan_regs_pkg::broadcast_cfg_reset;
      update_mode_cfg <= dual_chan_regs_pkg::update_cfg_reset;
      channel_code <= '{dual_chan_regs_pkg::code_reset, dual_chan_regs_pkg::code_reset};
      output_code <= '{dual_chan_regs_pkg::code_reset, dual_chan_regs_pkg::code_reset};
      alarm_clear_pulse <= 1'b0;
      soft_reset_pulse <= 1'b0;
      chan_a_power_down <= 1'b1;
      chan_b_power_down <= 1'b1;
      chan_a_range <= dual_chan_regs_pkg::range_0_5;
      chan_b_range <= dual_chan_regs_pkg::range_0_5;
      chan_a_output_code <= dual_chan_regs_pkg::code_reset;
      chan_b_output_code <= dual_chan_regs_pkg::code_reset;
    end else begin
      channel_power_down <= next_power_down;
      channel_output_range <= next_range;
      broadcast_enable_cfg <= next_bcast_cfg;
      update_mode_cfg <= next_update_cfg;
      channel_code <= next_code;
      output_code <= next_output;
      alarm_clear_pulse <= next_alarm_clear;
      soft_reset_pulse <= next_soft_reset;
      chan_a_power_down <= next_power_down[dual_chan_regs_pkg::chan_a_bit];
      chan_b_power_down <= next_power_down[dual_chan_regs_pkg::chan_b_bit];
      chan_a_range <= kind_a;
      chan_b_range <= kind_b;
      chan_a_output_code <= next_output[0];
      chan_b_output_code <= next_output[1];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Alarm clear request that a soft reset does not swallow
  sequence s_trig_bit8;
    wr_trigger && write_data[dual_chan_regs_pkg::alarm_clear_bit] && !do_reset;
  endsequence
  property p_reserved_ones;
    @(posedge clock) disable iff (!rst_n) channel_power_down[15:3] == 13'h1fff && channel_power_down[0];
  endproperty
  a_reserved_ones: assert property (p_reserved_ones) else $error("Reserved power-down bits not one");
  property p_pd_follows;
    @(posedge clock) disable iff (!rst_n)
      write_strobe && write_addr == dual_chan_regs_pkg::addr_channel_power_down && !do_reset |=>
      chan_a_power_down == $past(write_data[dual_chan_regs_pkg::chan_a_bit]);
  endproperty
  a_pd_follows: assert property (p_pd_follows) else $error("Channel A power-down not written");
  property p_clear;
    @(posedge clock) disable iff (!rst_n) do_clear |=> chan_a_output_code == 16'h0 && chan_b_output_code == 16'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("Outputs not cleared");
  property p_alarm_pulse;
    // A second request one cycle later may legally stretch the pulse
    @(posedge clock) disable iff (!rst_n)
      s_trig_bit8 |=> alarm_clear_pulse ##1
      (!alarm_clear_pulse || $past(wr_trigger && write_data[dual_chan_regs_pkg::alarm_clear_bit]));
  endproperty
  a_alarm_pulse: assert property (p_alarm_pulse) else $error("Alarm clear not one pulse");
  property p_soft_reset;
    @(posedge clock) disable iff (!rst_n)
      soft_reset_pulse |-> $past(wr_trigger) && $past(write_data[3:0]) == dual_chan_regs_pkg::soft_reset_code;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("Soft reset without code");
  property p_reset_pd;
    @(posedge clock) disable iff (!rst_n) do_reset |=> channel_power_down == 16'hffff && update_mode_cfg == 16'h0;
  endproperty
  a_reset_pd: assert property (p_reset_pd) else $error("Soft reset did not restore");
  property p_range_clean;
    @(posedge clock) disable iff (!rst_n) channel_output_range[15:12] == 4'h0 && channel_output_range[3:0] == 4'h0;
  endproperty
  a_range_clean: assert property (p_range_clean) else $error("Range reserved bits set");
  property p_bcast_off;
    @(posedge clock) disable iff (!rst_n)
      write_strobe && write_addr == dual_chan_regs_pkg::addr_broadcast_code &&
      !broadcast_enable_cfg[dual_chan_regs_pkg::chan_a_bit] && !do_reset |=> $stable(channel_code[0]);
  endproperty
  a_bcast_off: assert property (p_bcast_off) else $error("Disabled channel took broadcast");
  property p_sync_hold;
    @(posedge clock) disable iff (!rst_n)
      update_mode_cfg[1] && !do_load && !do_clear && !do_reset |=> $stable(output_code[0]);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("Sync channel updated without load");

endmodule

// [rtl/dual_chan_regs_pkg.sv]
// Package for the dual-channel converter register bank.
// Assumes a single 250 MHz clock domain; no other package is needed.
package dual_chan_regs_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [6:0] addr_channel_power_down = 7'h09; // Power-down controls
  localparam logic [6:0] addr_channel_output_range = 7'h0a; // Range codes
  localparam logic [6:0] addr_command_trigger = 7'h0e; // Self-clearing commands
  localparam logic [6:0] addr_broadcast_code = 7'h0f; // Broadcast word
  localparam logic [6:0] addr_channel_code_a = 7'h11; // Channel A code
  localparam logic [6:0] addr_channel_code_b = 7'h12; // Channel B code
  localparam logic [6:0] addr_broadcast_enable_cfg = 7'h05; // Broadcast enables
  localparam logic [6:0] addr_update_mode_cfg = 7'h06; // Sync-mode enables

  // ****************************************
  // Field positions
  // ****************************************
  localparam int chan_a_bit = 1; // Channel A bit in per-channel registers
  localparam int chan_b_bit = 2; // Channel B bit in per-channel registers
  localparam int range_a_lsb = 4; // Channel A range code low bit
  localparam int range_b_lsb = 8; // Channel B range code low bit
  localparam int clear_outputs_bit = 9; // Clear all outputs
  localparam int alarm_clear_bit = 8; // Clear latched alarm
  localparam int sync_load_bit = 4; // Load synchronous channels

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [15:0] power_down_reset = 16'hffff; // Both channels off
  localparam logic [15:0] range_reset = 16'h0000; // 0-5 V both channels
  localparam logic [15:0] code_reset = 16'h0000; // Zero code
  localparam logic [15:0] broadcast_cfg_reset = 16'h000f; // Both enabled
  localparam logic [15:0] update_cfg_reset = 16'h0000; // Asynchronous mode
  localparam logic [3:0] soft_reset_code = 4'ha; // Only code that resets

  // ****************************************
  // Decoded range kinds
  // ****************************************
  typedef enum logic [3:0] {
    range_0_5, range_0_6, range_0_10, range_0_12, range_0_20, range_0_24, range_0_40,
    range_pm5, range_pm6, range_pm10, range_pm12, range_pm20, range_invalid
  } range_kind_type;

endpackage

// [rtl/range_decoder.sv]
// Decodes one four-bit range code into a range kind.
// Assumes the code comes from a register; result is registered by the caller.
`timescale 1ns/1ps
module range_decoder (
  input wire logic [3:0] code,
  output dual_chan_regs_pkg::range_kind_type kind
);

  // ****************************************
  // Code table
  // ****************************************
  // Pure lookup; caller registers the result to keep outputs flop-driven
  always_comb begin
    case (code)
      4'h0: kind = dual_chan_regs_pkg::range_0_5;
      4'h8: kind = dual_chan_regs_pkg::range_0_6;
      4'h1: kind = dual_chan_regs_pkg::range_0_10;
      4'h9: kind = dual_chan_regs_pkg::range_0_12;
      4'h2: kind = dual_chan_regs_pkg::range_0_20;
      4'ha: kind = dual_chan_regs_pkg::range_0_24;
      4'h3: kind = dual_chan_regs_pkg::range_0_40;
      4'h5: kind = dual_chan_regs_pkg::range_pm5;
      4'hd: kind = dual_chan_regs_pkg::range_pm6;
      4'h6: kind = dual_chan_regs_pkg::range_pm10;
      4'he: kind = dual_chan_regs_pkg::range_pm12;
      4'h7: kind = dual_chan_regs_pkg::range_pm20;
      default: kind = dual_chan_regs_pkg::range_invalid;
    endcase
  end

endmodule

// [verification/dual_chan_regs_tb.sv]
// Self-checking bench for the dual-channel register bank.
// Assumes serial_host_model makes every write and pulse.
`timescale 1ns/1ps
module dual_chan_regs_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic clock; // 250 MHz
  logic rst_n; // Synchronous, active low
  logic write_strobe, select_rise, load_trigger_pin;
  logic [6:0] write_addr;
  logic [15:0] write_data, channel_power_down, out_a, out_b;
  logic [15:0] out_a12, out_b12; // Output codes of the 12-bit variant
  logic pd_a, pd_b, alarm_clear_pulse, soft_reset_pulse;
  dual_chan_regs_pkg::range_kind_type rng_a, rng_b;
  int fail_count = 0; // Mismatches
  int checks = 0; // Comparisons made
  logic [15:0] d, a, b; // Scratch and expected channel data

  // Clock, 4 ns period
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  serial_host_model serial_host_model_inst (.clock(clock), .write_strobe(write_strobe), .write_addr(write_addr),
    .write_data(write_data), .select_rise(select_rise), .load_trigger_pin(load_trigger_pin));
  dual_chan_regs dual_chan_regs_inst (.clock(clock), .rst_n(rst_n), .write_strobe(write_strobe),
    .write_addr(write_addr), .write_data(write_data), .select_rise(select_rise),
    .load_trigger_pin(load_trigger_pin), .channel_power_down(channel_power_down), .chan_a_power_down(pd_a),
    .chan_b_power_down(pd_b), .chan_a_range(rng_a), .chan_b_range(rng_b), .chan_a_output_code(out_a),
    .chan_b_output_code(out_b), .alarm_clear_pulse(alarm_clear_pulse), .soft_reset_pulse(soft_reset_pulse));
  // Same stimulus into the 12-bit variant, so its code masking is exercised
  dual_chan_regs #(.code_bits(12)) dual_chan_regs_narrow_inst (.clock(clock), .rst_n(rst_n),
    .write_strobe(write_strobe), .write_addr(write_addr), .write_data(write_data), .select_rise(select_rise),
    .load_trigger_pin(load_trigger_pin), .channel_power_down(), .chan_a_power_down(), .chan_b_power_down(),
    .chan_a_range(), .chan_b_range(), .chan_a_output_code(out_a12), .chan_b_output_code(out_b12),
    .alarm_clear_pulse(), .soft_reset_pulse());

  // ****************************************
  // Helpers
  // ****************************************
  // Compare and count
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Expected range kind of a four-bit code
  function automatic dual_chan_regs_pkg::range_kind_type range_exp(input logic [3:0] c);
    case (c)
      4'h0: return dual_chan_regs_pkg::range_0_5;
      4'h8: return dual_chan_regs_pkg::range_0_6;
      4'h1: return dual_chan_regs_pkg::range_0_10;
      4'h9: return dual_chan_regs_pkg::range_0_12;
      4'h2: return dual_chan_regs_pkg::range_0_20;
      4'ha: return dual_chan_regs_pkg::range_0_24;
      4'h3: return dual_chan_regs_pkg::range_0_40;
      4'h5: return dual_chan_regs_pkg::range_pm5;
      4'hd: return dual_chan_regs_pkg::range_pm6;
      4'h6: return dual_chan_regs_pkg::range_pm10;
      4'he: return dual_chan_regs_pkg::range_pm12;
      4'h7: return dual_chan_regs_pkg::range_pm20;
      default: return dual_chan_regs_pkg::range_invalid;
    endcase
  endfunction

  // Both live output codes, settled after the edge
  task automatic check_out(input logic [15:0] ea, input logic [15:0] eb);
    #1;
    check("out_a", ea, out_a);
    check("out_b", eb, out_b);
    // Narrow variant drops the low four bits of every code
    check("out_a12", ea & 16'hfff0, out_a12);
    check("out_b12", eb & 16'hfff0, out_b12);
  endtask

  // Verdict, the single place the run ends
  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog; the whole sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clock);
    fail_count++;
    test_done();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    void'($urandom(49));
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    check("pd_reg", 16'hffff, channel_power_down);
    check("pd_ab", 16'h0003, {14'h0000, pd_b, pd_a});
    check("rng_a", 16'(dual_chan_regs_pkg::range_0_5), 16'(rng_a));
    check_out(16'h0000, 16'h0000);
    // Power-down: only bits 2 and 1 move, reserved stay one
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 16'h0000 : 16'($urandom());
      serial_host_model_inst.write(7'h09, d);
      #1;
      check("pd_reg", 16'hfff9 | (d & 16'h0006), channel_power_down);
      check("pd_ab", {14'h0000, d[2], d[1]}, {14'h0000, pd_b, pd_a});
    end
    // Every range code on channel A, random on channel B
    for (int i = 0; i < 16; i++) begin
      d = {4'($urandom()), 4'($urandom()), 4'(i), 4'($urandom())};
      serial_host_model_inst.write(7'h0a, d);
      @(posedge clock);
      #1;
      check("rng_a", 16'(range_exp(d[7:4])), 16'(rng_a));
      check("rng_b", 16'(range_exp(d[11:8])), 16'(rng_b));
    end
    // Channel codes, an unmapped write, then asynchronous select
    a = 16'($urandom());
    b = 16'($urandom());
    serial_host_model_inst.write(7'h11, a);
    serial_host_model_inst.write(7'h12, b);
    serial_host_model_inst.write(7'h13, ~a);
    serial_host_model_inst.pulse(1'b0);
    check_out(a, b);
    // Broadcast with reset enables, then with random enables
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom());
      if (i > 0) begin
        serial_host_model_inst.write(7'h05, d);
      end
      a = (i == 0 || d[1]) ? d ^ 16'h5a5a : a;
      b = (i == 0 || d[2]) ? d ^ 16'h5a5a : b;
      serial_host_model_inst.write(7'h0f, d ^ 16'h5a5a);
      serial_host_model_inst.pulse(1'b0);
      check_out(a, b);
    end
    // Channel A synchronous: select moves B only
    serial_host_model_inst.write(7'h06, 16'h0002);
    serial_host_model_inst.write(7'h11, 16'h1234);
    serial_host_model_inst.write(7'h12, 16'hbeef);
    serial_host_model_inst.pulse(1'b0);
    check_out(a, 16'hbeef);
    serial_host_model_inst.write(7'h0e, 16'h0010);
    check_out(16'h1234, 16'hbeef);
    serial_host_model_inst.write(7'h11, 16'hc0de);
    serial_host_model_inst.pulse(1'b1);
    check_out(16'hc0de, 16'hbeef);
    // Clear, then a plain trigger write must not clear again
    serial_host_model_inst.write(7'h0e, 16'h0200);
    check_out(16'h0000, 16'h0000);
    serial_host_model_inst.pulse(1'b1);
    serial_host_model_inst.write(7'h0e, 16'h0000);
    check_out(16'hc0de, 16'h0000);
    // Alarm clear lasts exactly one cycle
    serial_host_model_inst.write(7'h0e, 16'h0100);
    #1;
    check("alarm", 16'h0001, {15'h0000, alarm_clear_pulse});
    @(posedge clock);
    #1;
    check("alarm", 16'h0000, {15'h0000, alarm_clear_pulse});
    // Every reset code; only one of them requests a reset
    for (int i = 0; i < 16; i++) begin
      serial_host_model_inst.write(7'h0e, {12'h000, 4'(i)});
      #1;
      check("soft_reset", {15'h0000, i == 10}, {15'h0000, soft_reset_pulse});
    end
    // Soft reset restored the defaults; later codes changed nothing
    check("pd_reg", 16'hffff, channel_power_down);
    check_out(16'h0000, 16'h0000);
    test_done();
  end
endmodule

// [verification/serial_host_model.sv]
// Host-side model: the frame decoder's write strobes, select and load pulses.
// Assumes one clock shared with the register bank; strobes last one cycle.
`timescale 1ns/1ps
module serial_host_model (
  input wire logic clock,
  output logic write_strobe,
  output logic [6:0] write_addr,
  output logic [15:0] write_data,
  output logic select_rise,
  output logic load_trigger_pin
);
  // ****************************************
  // Idle state
  // ****************************************
  // Quiet bus at time zero, before reset lets go
  initial begin
    write_strobe = 1'b0;
    write_addr = 7'h00;
    write_data = 16'h0000;
    select_rise = 1'b0;
    load_trigger_pin = 1'b0;
  end

  // ****************************************
  // Transfers
  // ****************************************
  // One register write; the bus shows inverted junk once released
  task automatic write(input logic [6:0] addr, input logic [15:0] data);
    @(posedge clock);
    write_strobe <= 1'b1;
    write_addr <= addr;
    write_data <= data;
    @(posedge clock);
    write_strobe <= 1'b0;
    write_addr <= ~addr;
    write_data <= ~data;
  endtask

  // One-cycle pulse on select or on the load pin
  task automatic pulse(input logic on_load);
    @(posedge clock);
    if (on_load) begin
      load_trigger_pin <= 1'b1;
    end else begin
      select_rise <= 1'b1;
    end
    @(posedge clock);
    load_trigger_pin <= 1'b0;
    select_rise <= 1'b0;
  endtask
endmodule
